//--- design/rgc_regulator_ctrl.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rgc_regulator_ctrl
   import rgc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire rgc_fault_type i_fault,
   input wire logic [2:0] i_sel_code,
   input wire logic i_sel_to_gnd,
   input wire logic i_low_side_gate_pin_conn,
   input wire logic i_low_power_off_mode_wake,
   output logic o_pre_en,
   output logic o_core_en,
   output logic o_ana_en,
   output logic o_aux_en,
   output logic o_aux_track,
   output rgc_hwcfg_type o_hwcfg,
   output logic o_dfs_fs,
   output logic o_bat_warn,
   output logic o_int_n
);

   // ****************************************
   // Functions
   // ****************************************
   function automatic logic [31:0] rgc_merge(input logic [31:0] old_d,
                                             input logic [31:0] new_d,
                                             input logic [3:0] strb);
      logic [31:0] mask;
      mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old_d & ~mask) | (new_d & mask);
   endfunction
   function automatic logic rgc_mapped(input logic [7:0] addr);
      return (addr == RGC_CTRL_OFS) || (addr == RGC_DIAG_OFS) ||
             (addr == RGC_HWCFG_OFS) || (addr == RGC_INTCFG_OFS) ||
             (addr == RGC_STAT_OFS);
   endfunction

   // Returns {open, aux 5 V, analog-ref 5 V}
   function automatic logic [2:0] rgc_decode(input logic [2:0] code);
      unique case (code)
         RGC_SEL_33_33: return 3'h0;
         RGC_SEL_50_50: return 3'h3;
         RGC_SEL_33_50: return 3'h2;
         RGC_SEL_50_33: return 3'h1;
         default: return 3'h4;
      endcase
   endfunction

   // ****************************************
   // Register bus slave
   // ****************************************
   logic awready_reg, wready_reg, aw_full_reg, w_full_reg;
   logic bvalid_reg, arready_reg, rvalid_reg;
   logic do_write, wr_ctrl, wr_diag, wr_icfg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, rdata_reg, rdata_next;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_ctrl = do_write && (aw_addr_reg == RGC_CTRL_OFS);
   assign wr_diag = do_write && (aw_addr_reg == RGC_DIAG_OFS);
   assign wr_icfg = do_write && (aw_addr_reg == RGC_INTCFG_OFS);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         awready_reg <= 1'b1;
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (i_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         aw_full_reg <= 1'b1;
         aw_addr_reg <= i_awaddr;
      end else if (do_write) begin
         aw_full_reg <= 1'b0;
      end else if (bvalid_reg && i_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wready_reg <= 1'b1;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
      end else if (i_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         w_full_reg <= 1'b1;
         w_data_reg <= i_wdata;
         w_strb_reg <= i_wstrb;
      end else if (do_write) begin
         w_full_reg <= 1'b0;
      end else if (bvalid_reg && i_bready) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RGC_RESP_OK;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= rgc_mapped(aw_addr_reg) ? RGC_RESP_OK : RGC_RESP_ERR;
      end else if (i_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= RGC_RESP_OK;
      end else if (i_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rdata_next;
         rresp_reg <= rgc_mapped(i_araddr) ? RGC_RESP_OK : RGC_RESP_ERR;
      end else if (rvalid_reg && i_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // ****************************************
   // Supply enables and control
   // ****************************************
   logic [4:0] ctrl_reg;
   logic [31:0] ctrl_wr;
   logic pre_en_reg;
   assign ctrl_wr = rgc_merge({27'h0, ctrl_reg}, w_data_reg, w_strb_reg);

   always_ff @(posedge i_clk) begin
      pre_en_reg <= i_rst_n;
   end

   // Fault shutdown is assigned last so it beats a same-cycle enable
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg <= RGC_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_wr[4:0];
         end
         if (i_fault.core_ov) begin
            ctrl_reg[RGC_CTRL_CORE] <= 1'b0;
         end
         if (i_fault.ana_ov || (i_fault.ana_oc && ctrl_reg[RGC_CTRL_PNP])) begin
            ctrl_reg[RGC_CTRL_ANA] <= 1'b0;
         end
         if (i_fault.aux_ov || i_fault.aux_oc) begin
            ctrl_reg[RGC_CTRL_AUX] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Diagnostics and battery warning
   // ****************************************
   logic [5:0] diag_reg, diag_clr;
   logic [31:0] diag_wr;
   logic bat_warn_reg, new_evt;
   assign diag_wr = rgc_merge(32'h0, w_data_reg, w_strb_reg);
   assign diag_clr = wr_diag ? diag_wr[5:0] : 6'h00;
   assign new_evt = |(i_fault & ~diag_reg);

   // Write one clears; a fault in the same cycle wins
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         diag_reg <= RGC_DIAG_RST;
      end else begin
         diag_reg <= (diag_reg & ~diag_clr) | i_fault;
      end
   end

   always_ff @(posedge i_clk) begin
      bat_warn_reg <= i_rst_n && i_fault.bat_low;
   end

   // ****************************************
   // Hardware configuration latch
   // ****************************************
   logic cfg_pend_reg, cfg_take, dfs_fs_reg;
   logic [2:0] sel_dec;
   rgc_hwcfg_type hwcfg_reg;
   assign cfg_take = cfg_pend_reg || i_low_power_off_mode_wake;
   assign sel_dec = rgc_decode(i_sel_code);

   always_ff @(posedge i_clk) begin
      cfg_pend_reg <= !i_rst_n;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hwcfg_reg <= '0;
      end else if (cfg_take) begin
         hwcfg_reg.sel_open <= sel_dec[2];
         hwcfg_reg.aux_5v <= sel_dec[1];
         hwcfg_reg.ana_5v <= sel_dec[0];
         hwcfg_reg.dfs <= i_sel_to_gnd;
         hwcfg_reg.buckboost <= i_low_side_gate_pin_conn;
      end
   end

   // Separate fail-safe copy so one upset cannot flip both
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dfs_fs_reg <= 1'b0;
      end else if (cfg_take) begin
         dfs_fs_reg <= i_sel_to_gnd;
      end
   end

   // ****************************************
   // Interrupt pulse
   // ****************************************
   logic [5:0] icfg_reg;
   logic [31:0] icfg_wr;
   rgc_int_state_type int_state_reg;
   logic [RGC_INT_CNT_W-1:0] int_cnt_reg, int_len;
   logic int_pend_reg, int_n_reg;
   assign icfg_wr = rgc_merge({26'h0, icfg_reg}, w_data_reg, w_strb_reg);
   assign int_len = RGC_INT_CNT_W'((int'(icfg_reg[RGC_ICFG_LEN_MSB:0]) + 1) *
                                   RGC_INT_UNIT_CYC);

   // Settings freeze once lock is set, until reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         icfg_reg <= RGC_ICFG_RST;
      end else if (wr_icfg && !icfg_reg[RGC_ICFG_LOCK]) begin
         icfg_reg <= icfg_wr[5:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         int_pend_reg <= 1'b0;
      end else if (int_state_reg == RGC_INT_IDLE) begin
         int_pend_reg <= 1'b0;
      end else if (new_evt && icfg_reg[RGC_ICFG_EN]) begin
         int_pend_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         int_state_reg <= RGC_INT_IDLE;
         int_cnt_reg <= '0;
         int_n_reg <= 1'b1;
      end else begin
         unique case (int_state_reg)
            RGC_INT_IDLE: begin
               if ((new_evt && icfg_reg[RGC_ICFG_EN]) || int_pend_reg) begin
                  int_state_reg <= RGC_INT_LOW;
                  int_cnt_reg <= int_len;
                  int_n_reg <= 1'b0;
               end
            end
            RGC_INT_LOW: begin
               if (int_cnt_reg == RGC_INT_CNT_W'(1)) begin
                  int_state_reg <= RGC_INT_GAP;
                  int_n_reg <= 1'b1;
               end
               int_cnt_reg <= int_cnt_reg - RGC_INT_CNT_W'(1);
            end
            RGC_INT_GAP: begin
               int_state_reg <= RGC_INT_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Read mux and outputs
   // ****************************************
   always_comb begin
      rdata_next = 32'h0;
      unique case (i_araddr)
         RGC_CTRL_OFS: rdata_next = {27'h0, ctrl_reg};
         RGC_DIAG_OFS: rdata_next = {26'h0, diag_reg};
         RGC_HWCFG_OFS: rdata_next = {27'h0, hwcfg_reg};
         RGC_INTCFG_OFS: rdata_next = {26'h0, icfg_reg};
         RGC_STAT_OFS: rdata_next = {25'h0, int_n_reg, i_fault};
         default: rdata_next = 32'h0;
      endcase
   end
   assign {o_awready, o_wready, o_arready} = {awready_reg, wready_reg, arready_reg};
   assign {o_bvalid, o_bresp} = {bvalid_reg, bresp_reg};
   assign {o_rvalid, o_rresp, o_rdata} = {rvalid_reg, rresp_reg, rdata_reg};
   assign o_pre_en = pre_en_reg;
   assign o_core_en = ctrl_reg[RGC_CTRL_CORE];
   assign o_ana_en = ctrl_reg[RGC_CTRL_ANA];
   assign o_aux_en = ctrl_reg[RGC_CTRL_AUX];
   assign o_aux_track = ctrl_reg[RGC_CTRL_TRACK];
   assign o_hwcfg = hwcfg_reg;
   assign {o_dfs_fs, o_bat_warn, o_int_n} = {dfs_fs_reg, bat_warn_reg, int_n_reg};

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_int_start;
      int_state_reg == RGC_INT_IDLE && new_evt && icfg_reg[RGC_ICFG_EN];
   endsequence
   sequence s_int_low;
      !o_int_n [*8];
   endsequence
   property p_int_pulse;
      s_int_start |=> s_int_low;
   endproperty
   a_pre_always_on: assert property ($past(i_rst_n) |-> o_pre_en)
      else $error("pre-regulator enable dropped");
   a_reset_defaults: assert property ($rose(i_rst_n) |->
      o_core_en && o_ana_en && o_aux_en)
      else $error("supply enables not on after reset");
   a_core_ov_off: assert property (i_fault.core_ov |=> !o_core_en)
      else $error("core supply left on after overvoltage");
   a_ana_oc_pnp: assert property (i_fault.ana_oc && ctrl_reg[RGC_CTRL_PNP]
      |=> !o_ana_en)
      else $error("analog-ref left on after overcurrent");
   a_aux_fault_log: assert property ((i_fault.aux_ov || i_fault.aux_oc)
      |=> !o_aux_en && (diag_reg[3] || diag_reg[4]))
      else $error("auxiliary fault not handled");
   a_core_stays_off: assert property (!o_core_en && !wr_ctrl
      |=> !o_core_en)
      else $error("core supply re-enabled without host");
   a_core_sw_on: assert property (wr_ctrl && w_strb_reg[0] && w_data_reg[0]
      && !i_fault.core_ov |=> o_core_en)
      else $error("core supply enable write lost");
   a_cfg_hold: assert property (!cfg_take |=> $stable(o_hwcfg)
      && $stable(o_dfs_fs))
      else $error("configuration latch changed");
   a_open_min_volt: assert property (cfg_take && i_sel_code == RGC_SEL_OPEN
      |=> !o_hwcfg.ana_5v && !o_hwcfg.aux_5v)
      else $error("open strap not at 3.3 V");
   a_dfs_copies: assert property (cfg_take |=> o_hwcfg.dfs == $past(i_sel_to_gnd)
      && o_dfs_fs == o_hwcfg.dfs)
      else $error("deep fail-safe copies disagree");
   a_mode_detect: assert property (cfg_take
      |=> o_hwcfg.buckboost == $past(i_low_side_gate_pin_conn))
      else $error("converter mode not latched");
   a_bat_flag: assert property (i_fault.bat_low |=> o_bat_warn)
      else $error("battery warning missing");
   a_int_pulse: assert property (p_int_pulse)
      else $error("interrupt pulse too short");
endmodule
`default_nettype wire

//--- pkg/rgc_pkg.sv
`default_nettype none
package rgc_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int RGC_CLK_NS = 10;
   localparam int RGC_INT_UNIT_NS = 1000;
   localparam int RGC_INT_UNIT_CYC = (RGC_INT_UNIT_NS > RGC_CLK_NS) ?
      RGC_INT_UNIT_NS / RGC_CLK_NS : 1;
   localparam int RGC_INT_CNT_W = 11;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] RGC_CTRL_OFS = 8'h00;
   localparam logic [7:0] RGC_DIAG_OFS = 8'h04;
   localparam logic [7:0] RGC_HWCFG_OFS = 8'h08;
   localparam logic [7:0] RGC_INTCFG_OFS = 8'h0C;
   localparam logic [7:0] RGC_STAT_OFS = 8'h10;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int RGC_CTRL_CORE = 0;
   localparam int RGC_CTRL_ANA = 1;
   localparam int RGC_CTRL_AUX = 2;
   localparam int RGC_CTRL_TRACK = 3;
   localparam int RGC_CTRL_PNP = 4;
   localparam logic [4:0] RGC_CTRL_RST = 5'h07;
   localparam int RGC_ICFG_LEN_MSB = 3;
   localparam int RGC_ICFG_LOCK = 4;
   localparam int RGC_ICFG_EN = 5;
   localparam logic [5:0] RGC_ICFG_RST = 6'h23;
   localparam logic [5:0] RGC_DIAG_RST = 6'h00;
   localparam logic [1:0] RGC_RESP_OK = 2'h0;
   localparam logic [1:0] RGC_RESP_ERR = 2'h2;

   // ****************************************
   // Strap resistor range codes
   // ****************************************
   localparam logic [2:0] RGC_SEL_OPEN = 3'h0;
   localparam logic [2:0] RGC_SEL_33_33 = 3'h1;
   localparam logic [2:0] RGC_SEL_50_50 = 3'h2;
   localparam logic [2:0] RGC_SEL_33_50 = 3'h3;
   localparam logic [2:0] RGC_SEL_50_33 = 3'h4;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic bat_low;
      logic aux_oc;
      logic aux_ov;
      logic ana_oc;
      logic ana_ov;
      logic core_ov;
   } rgc_fault_type;

   typedef struct packed {
      logic sel_open;
      logic buckboost;
      logic dfs;
      logic aux_5v;
      logic ana_5v;
   } rgc_hwcfg_type;

   typedef enum logic [1:0] {
      RGC_INT_IDLE = 2'h0,
      RGC_INT_LOW = 2'h1,
      RGC_INT_GAP = 2'h3
   } rgc_int_state_type;
endpackage
`default_nettype wire

//--- tb/regulator_control_hw_config_test.sv
`timescale 1ns/10ps
`default_nettype none
module regulator_control_hw_config_test
   import rgc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n, to_gnd, gate, wake;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic pre_en, core_en, ana_en, aux_en, track, dfs_fs, bat_warn, int_n;
   logic [2:0] sel_code;
   rgc_hwcfg_type hwcfg;
   rgc_fault_type fault_s;
   int error_cnt = 0;
   int compares = 0;

   always #5 clk = ~clk;

   rgc_host_model host_u (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
      .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
      .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

   rgc_regulator_ctrl dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_fault(fault_s), .i_sel_code(sel_code), .i_sel_to_gnd(to_gnd),
      .i_low_side_gate_pin_conn(gate), .i_low_power_off_mode_wake(wake), .o_pre_en(pre_en), .o_core_en(core_en),
      .o_ana_en(ana_en), .o_aux_en(aux_en), .o_aux_track(track), .o_hwcfg(hwcfg),
      .o_dfs_fs(dfs_fs), .o_bat_warn(bat_warn), .o_int_n(int_n));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("Compares %0d, errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic [4:0] exp_hw(input logic [2:0] c, input logic g);
      logic [1:0] v;
      v = 2'h0;
      if (c == RGC_SEL_50_50) v = 2'h3;
      if (c == RGC_SEL_33_50) v = 2'h2;
      if (c == RGC_SEL_50_33) v = 2'h1;
      return {(c == RGC_SEL_OPEN || c > 3'h4), gate, g, v};
   endfunction

   // One-cycle fault, then time for the enable to drop
   task automatic pulse(input logic [5:0] f);
      @(posedge clk);
      fault_s <= f;
      @(posedge clk);
      fault_s <= 6'h00;
      repeat (2) @(negedge clk);
   endtask

   task automatic reg_is(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      host_u.rd(a, d, r);
      chk(d, e);
      chk(r, er);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      host_u.wr(a, d, r);
      chk(r, er);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      repeat (2) @(negedge clk);
      chk(pre_en, 1'b1);
      chk({aux_en, ana_en, core_en}, 3'h7);
      chk(hwcfg, 5'h0E);
      chk(dfs_fs, 1'b1);
      reg_is(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      reg_is(RGC_HWCFG_OFS, 32'hE, RGC_RESP_OK);
   endtask

   task automatic t_ctrl;
      reg_wr(RGC_CTRL_OFS, 32'h8, RGC_RESP_OK); // No supply is safety critical here
      @(negedge clk);
      chk({track, aux_en, ana_en, core_en}, 4'h8);
      chk(pre_en, 1'b1);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      @(negedge clk);
      chk({track, aux_en, ana_en, core_en}, 4'h7);
   endtask

   task automatic t_core;
      int n;
      n = 0;
      @(posedge clk);
      fault_s <= 6'h01;
      @(posedge clk);
      fault_s <= 6'h00;
      repeat (450) begin
         @(negedge clk);
         if (int_n === 1'b0) n++;
      end
      chk(n, 32'd400);
      chk(core_en, 1'b0);
      reg_is(RGC_DIAG_OFS, 32'h1, RGC_RESP_OK);
      reg_is(RGC_CTRL_OFS, 32'h6, RGC_RESP_OK);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      @(negedge clk);
      chk(core_en, 1'b1);
      reg_wr(RGC_DIAG_OFS, 32'h3F, RGC_RESP_OK);
      reg_is(RGC_DIAG_OFS, 32'h0, RGC_RESP_OK);
   endtask

   task automatic t_ana;
      pulse(6'h04);
      chk(ana_en, 1'b1);
      reg_wr(RGC_CTRL_OFS, 32'h17, RGC_RESP_OK);
      pulse(6'h04);
      chk(ana_en, 1'b0);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      pulse(6'h02);
      chk(ana_en, 1'b0);
      reg_is(RGC_DIAG_OFS, 32'h6, RGC_RESP_OK);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      reg_wr(RGC_DIAG_OFS, 32'h3F, RGC_RESP_OK);
   endtask

   task automatic t_aux;
      pulse(6'h10);
      chk(aux_en, 1'b0);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      pulse(6'h08);
      chk(aux_en, 1'b0);
      reg_is(RGC_DIAG_OFS, 32'h18, RGC_RESP_OK);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      @(posedge clk);
      fault_s <= 6'h20;
      repeat (2) @(negedge clk);
      chk(bat_warn, 1'b1);
      @(posedge clk);
      fault_s <= 6'h00;
      repeat (2) @(negedge clk);
      chk(bat_warn, 1'b0);
   endtask

   task automatic t_strap;
      @(posedge clk);
      sel_code <= RGC_SEL_50_50;
      to_gnd <= 1'b0;
      repeat (3) @(negedge clk);
      chk(hwcfg, 5'h0E);
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         sel_code <= c[2:0];
         to_gnd <= c[0];
         gate <= c[1];
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         repeat (2) @(negedge clk);
         chk(hwcfg, exp_hw(c[2:0], c[0]));
         chk(dfs_fs, c[0]);
      end
      reg_is(RGC_HWCFG_OFS, {27'h0, exp_hw(3'h7, 1'b1)}, RGC_RESP_OK);
   endtask

   task automatic t_err;
      reg_wr(8'h14, 32'h0, RGC_RESP_ERR);
      reg_is(8'h14, 32'h0, RGC_RESP_ERR);
      reg_wr(RGC_HWCFG_OFS, 32'hFF, RGC_RESP_OK);
      reg_is(RGC_HWCFG_OFS, {27'h0, exp_hw(3'h7, 1'b1)}, RGC_RESP_OK);
   endtask

   // Locked short pulse setting, live status, then a 100-cycle pulse
   task automatic t_icfg;
      int n;
      n = 0;
      reg_wr(RGC_INTCFG_OFS, 32'h30, RGC_RESP_OK);
      reg_wr(RGC_INTCFG_OFS, 32'h23, RGC_RESP_OK);
      reg_is(RGC_INTCFG_OFS, 32'h30, RGC_RESP_OK);
      repeat (1000) @(negedge clk);
      reg_is(RGC_STAT_OFS, 32'h40, RGC_RESP_OK);
      @(posedge clk);
      fault_s <= 6'h01;
      @(posedge clk);
      fault_s <= 6'h00;
      repeat (150) begin
         @(negedge clk);
         if (int_n === 1'b0) n++;
      end
      chk(n, 32'd100);
      reg_wr(RGC_CTRL_OFS, 32'h7, RGC_RESP_OK);
      @(negedge clk);
      chk(core_en, 1'b1);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      rst_n <= 1'b0;
      fault_s <= 6'h00;
      sel_code <= RGC_SEL_33_50;
      to_gnd <= 1'b1;
      gate <= 1'b1;
      wake <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ctrl();
      t_core();
      t_ana();
      t_aux();
      t_strap();
      t_err();
      t_icfg();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule
`default_nettype wire

//--- tb/rgc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rgc_host_model (
   input wire logic i_clk,
   output logic [7:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   output logic [7:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   // ****************************************
   // Host side of the register bus
   // ****************************************
   initial begin
      o_awaddr = 8'h00;
      o_awvalid = 1'b0;
      o_wdata = 32'h0;
      o_wstrb = 4'hF;
      o_wvalid = 1'b0;
      o_bready = 1'b0;
      o_araddr = 8'h00;
      o_arvalid = 1'b0;
      o_rready = 1'b0;
   end

   // Released payloads show inverted data, never the last value
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_awvalid && i_awready) begin
            o_awvalid <= 1'b0;
            o_awaddr <= ~a;
         end
         if (o_wvalid && i_wready) begin
            o_wvalid <= 1'b0;
            o_wdata <= ~d;
         end
      end while (!i_bvalid);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_arvalid && i_arready) begin
            o_arvalid <= 1'b0;
            o_araddr <= ~a;
         end
      end while (!i_rvalid);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire
